// >>> include/smpc_map.vh
`ifndef SMPC_MAP_VH
`define SMPC_MAP_VH
// Register byte offsets.
`define SMPC_OFS_CTRL1 8'h00
`define SMPC_OFS_CTRL2 8'h04
`define SMPC_OFS_CLKSRC 8'h08
`define SMPC_OFS_STATUS 8'h0C
// Fields of power_mgmt_status_ctrl1.
`define SMPC_C1_STOP_EN 0
`define SMPC_C1_DET_EN 1
`define SMPC_C1_DET_STOP 2
`define SMPC_C1_DBG 3
`define SMPC_C1_RTCEN 4
`define SMPC_C1_ADACK 5
`define SMPC_C1_BGREF 6
`define SMPC_C1_RESET 7'h03
// Fields of power_mgmt_status_ctrl2.
`define SMPC_C2_PD_SEL 0
`define SMPC_C2_PD_ACK 1
`define SMPC_C2_PD_FLAG 2
// Fields of the clock source control register.
`define SMPC_CS_IREF_EN 0
`define SMPC_CS_IREF_STOP 1
`define SMPC_CS_EREF_EN 2
`define SMPC_CS_EREF_STOP 3
`define SMPC_CS_RANGE 4
`define SMPC_CS_RESET 8'h01
// Reset vector address, high byte first.
`define SMPC_VEC_HI 16'hFFFE
`define SMPC_VEC_LO 16'hFFFF
// AXI responses.
`define SMPC_RESP_OKAY 2'h0
`define SMPC_RESP_SLVERR 2'h2
// Cycles the power-on-style restart is held after wake.
`define SMPC_POR_CYCLES 4'h8
`endif

// >>> hdl/smpc_sync_reg.v
`timescale 1ns/1ps
// Register with async reset to INIT and a load enable, used for control latches.
module smpc_sync_reg #(
   parameter W = 8,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clk,
   input wire reset_n,
   input wire load,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   // Reset takes the constant only; loads happen on the clock.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= INIT;
      end else if (load) begin
         q <= d;
      end
   end
endmodule

// >>> hdl/smpc_top.v
// How it works
// - Deep powerdown drops core power, keeps RAM powered.
// - Entering deep powerdown latches all pin control signals.
// - Low wake reset pin ends deep powerdown.
// - Enabled real-time counter event also wakes; disabled one does not.
// - Wake restarts like power-on, resetting module registers.
// - Wake enables low-voltage reset, low trip; hold reset while low.
// - After wake release, processor fetches the reset vector.
// - Every deep powerdown wake sets the partial powerdown flag.
// - Flag and pin latches hold until acknowledge written with 1.
// - On latch release pins follow their present controller.
// - Any stop state halts peripheral clocks, even with debug on.
// - Debug enable turns a deep powerdown request into light stop.
// - Low-voltage stop enable with detector enable on turns deep request into light stop.
// - Converter runs in light stop only with async clock and detector.
// - Bandgap comparator runs in light stop with detector on or bandgap bit clear.
// - Internal reference runs in light stop only with both enables.
// - Oscillator needs both enables; high range also needs detector.
// - Regulator stays on in light stop if debug or detector on.
// - Stop with stop enable clear gives an illegal-opcode reset.
// - Reset vector read from the top two bytes, high byte first.
// - Interrupt wake from light stop returns straight to run, with no restart or vector fetch.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "smpc_map.vh"
module smpc_top (
   input wire clk,
   input wire reset_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire stop_request,
   input wire wake_reset_n,
   input wire rtc_event,
   input wire supply_below_low,
   input wire irq_wake,
   input wire [7:0] pin_ctrl_live,
   output reg [7:0] pin_ctrl_out,
   output reg core_power_on,
   output reg ram_power_on,
   output reg periph_clk_en,
   output reg debug_clk_en,
   output reg system_reset_n,
   output reg illegal_op_reset,
   output reg volt_reset_en,
   output reg volt_low_trip,
   output reg fetch_reset_vector,
   output reg [15:0] vector_addr,
   output reg adc_run,
   output reg comparator_run,
   output reg irc_run,
   output reg ext_osc_run,
   output reg regulator_full,
   output reg light_stop_active,
   output reg deep_powerdown_active
);
   ////////////////////////////////////////////////////////////////////////
   // States of the stop sequencer.
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_LIGHT = 3'h1;
   localparam [2:0] ST_DEEP = 3'h2;
   localparam [2:0] ST_RESTART = 3'h3;
   localparam [2:0] ST_LVHOLD = 3'h4;
   localparam [2:0] ST_ILLEGAL = 3'h5;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [3:0] por_cnt_reg;
   reg flag_reg;
   reg latched_reg;
   reg [7:0] pin_hold_reg;
   wire [6:0] ctrl1_q;
   wire [7:0] clksrc_q;
   reg pd_select_reg;
   reg det_on_entry_reg;
   reg dbg_on_entry_reg;
   wire [6:0] ctrl1_next;
   wire [7:0] clksrc_next;
   wire ctrl1_load;
   wire clksrc_load;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave. Address and data may come in either order; each is
   // taken once and the response follows when both are held.
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   wire wr_go;
   wire ack_write;
   reg [31:0] rd_word;
   reg rd_ok;

   assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign ctrl1_load = wr_go && wstrb_reg[0] &&
                       awaddr_reg == `SMPC_OFS_CTRL1;
   assign clksrc_load = wr_go && wstrb_reg[0] &&
                        awaddr_reg == `SMPC_OFS_CLKSRC;
   assign ctrl1_next = wdata_reg[6:0];
   assign clksrc_next = wdata_reg[7:0];
   // A 0 in the acknowledge bit leaves the flag and pin latches alone.
   assign ack_write = wr_go && wstrb_reg[0] &&
                      awaddr_reg == `SMPC_OFS_CTRL2 &&
                      wdata_reg[`SMPC_C2_PD_ACK];

   // Write channel capture and response.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SMPC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_reg)
               `SMPC_OFS_CTRL1, `SMPC_OFS_CTRL2, `SMPC_OFS_CLKSRC,
               `SMPC_OFS_STATUS: s_axi_bresp <= `SMPC_RESP_OKAY;
               default: s_axi_bresp <= `SMPC_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read decode; the flag is visible but has no write path.
   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `SMPC_OFS_CTRL1: rd_word[6:0] = ctrl1_q;
         `SMPC_OFS_CTRL2: begin
            rd_word[`SMPC_C2_PD_SEL] = pd_select_reg;
            rd_word[`SMPC_C2_PD_FLAG] = flag_reg;
         end
         `SMPC_OFS_CLKSRC: rd_word[7:0] = clksrc_q;
         `SMPC_OFS_STATUS: begin
            rd_word[2:0] = state_reg;
            rd_word[3] = latched_reg;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel: one cycle to accept, data registered with rvalid.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SMPC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `SMPC_RESP_OKAY : `SMPC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Module control registers; a wake restart returns them to reset.
   wire restart_clear;
   assign restart_clear = state_reg == ST_RESTART;

   smpc_sync_reg #(.W(7), .INIT(`SMPC_C1_RESET)) u_ctrl1 (
      .clk(clk),
      .reset_n(reset_n),
      .load(ctrl1_load || restart_clear),
      .d(restart_clear ? `SMPC_C1_RESET : ctrl1_next),
      .q(ctrl1_q)
   );

   smpc_sync_reg #(.W(8), .INIT(`SMPC_CS_RESET)) u_clksrc (
      .clk(clk),
      .reset_n(reset_n),
      .load(clksrc_load || restart_clear),
      .d(restart_clear ? `SMPC_CS_RESET : clksrc_next),
      .q(clksrc_q)
   );

   // Partial powerdown select lives beside the flag in control 2.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_select_reg <= 1'b0;
      end else if (restart_clear) begin
         pd_select_reg <= 1'b0;
      end else if (wr_go && wstrb_reg[0] &&
                   awaddr_reg == `SMPC_OFS_CTRL2) begin
         pd_select_reg <= wdata_reg[`SMPC_C2_PD_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stop sequencer.
   wire stop_en = ctrl1_q[`SMPC_C1_STOP_EN];
   wire det_en = ctrl1_q[`SMPC_C1_DET_EN];
   wire det_stop_en = ctrl1_q[`SMPC_C1_DET_STOP];
   wire dbg_en = ctrl1_q[`SMPC_C1_DBG];
   wire det_in_stop = det_en && det_stop_en;
   // Debug or a live detector downgrades a deep request.
   wire go_deep = pd_select_reg && !dbg_en && !det_in_stop;
   // Entry options are taken live on the entry edge and from the capture
   // after it, so the first stop cycle already has the right power mix.
   wire det_entry = (state_reg == ST_RUN) ? det_in_stop : det_on_entry_reg;
   wire dbg_entry = (state_reg == ST_RUN) ? dbg_en : dbg_on_entry_reg;
   wire deep_wake = !wake_reset_n ||
                    (rtc_event && ctrl1_q[`SMPC_C1_RTCEN]);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (stop_request) begin
               if (!stop_en) begin
                  state_next = ST_ILLEGAL;
               end else if (go_deep) begin
                  state_next = ST_DEEP;
               end else begin
                  state_next = ST_LIGHT;
               end
            end
         end
         ST_LIGHT: begin
            if (!wake_reset_n) begin
               state_next = ST_RESTART;
            end else if (irq_wake) begin
               state_next = ST_RUN;
            end
         end
         ST_DEEP: begin
            if (deep_wake) begin
               state_next = ST_RESTART;
            end
         end
         ST_RESTART: begin
            if (por_cnt_reg == 4'h0) begin
               state_next = ST_LVHOLD;
            end
         end
         ST_LVHOLD: begin
            if (!supply_below_low) begin
               state_next = ST_RUN;
            end
         end
         ST_ILLEGAL: state_next = ST_RESTART;
         default: state_next = ST_RUN;
      endcase
   end

   // State, restart counter and the wake flag.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_RUN;
         por_cnt_reg <= 4'h0;
         flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg != ST_RESTART && state_next == ST_RESTART) begin
            por_cnt_reg <= `SMPC_POR_CYCLES;
         end else if (por_cnt_reg != 4'h0) begin
            por_cnt_reg <= por_cnt_reg - 4'h1;
         end
         // Wake sets win over a same-cycle acknowledge.
         if (state_reg == ST_DEEP && deep_wake) begin
            flag_reg <= 1'b1;
         end else if (ack_write) begin
            flag_reg <= 1'b0;
         end
      end
   end

   // Entry conditions sampled at stop entry, for light stop options.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         det_on_entry_reg <= 1'b0;
         dbg_on_entry_reg <= 1'b0;
      end else if (state_reg == ST_RUN && stop_request) begin
         det_on_entry_reg <= det_in_stop;
         dbg_on_entry_reg <= dbg_en;
      end
   end

   // Pin latches: closed on deep entry, opened only by acknowledge. A
   // pin then follows whatever controller drives pin_ctrl_live, so
   // software must restore ports and peripherals first.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latched_reg <= 1'b0;
         pin_hold_reg <= 8'h00;
      end else if (state_reg == ST_RUN && state_next == ST_DEEP) begin
         latched_reg <= 1'b1;
         pin_hold_reg <= pin_ctrl_live;
      end else if (ack_write && !(state_reg == ST_DEEP && deep_wake)) begin
         latched_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs from state and configuration.
   wire in_light = state_next == ST_LIGHT;
   wire in_deep = state_next == ST_DEEP;
   wire in_rst = state_next == ST_RESTART || state_next == ST_LVHOLD ||
                 state_next == ST_ILLEGAL;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_ctrl_out <= 8'h00;
         core_power_on <= 1'b1;
         ram_power_on <= 1'b1;
         periph_clk_en <= 1'b1;
         debug_clk_en <= 1'b1;
         system_reset_n <= 1'b0;
         illegal_op_reset <= 1'b0;
         volt_reset_en <= 1'b1;
         volt_low_trip <= 1'b1;
         fetch_reset_vector <= 1'b0;
         vector_addr <= `SMPC_VEC_HI;
         adc_run <= 1'b0;
         comparator_run <= 1'b0;
         irc_run <= 1'b0;
         ext_osc_run <= 1'b0;
         regulator_full <= 1'b1;
         light_stop_active <= 1'b0;
         deep_powerdown_active <= 1'b0;
      end else begin
         pin_ctrl_out <= (latched_reg || in_deep) ?
                         (latched_reg ? pin_hold_reg : pin_ctrl_live) :
                         pin_ctrl_live;
         core_power_on <= !in_deep;
         ram_power_on <= 1'b1;
         periph_clk_en <= !(in_light || in_deep);
         debug_clk_en <= !in_deep && !(in_light && !dbg_entry);
         system_reset_n <= !in_rst && !in_deep;
         illegal_op_reset <= state_next == ST_ILLEGAL;
         if (state_next == ST_RESTART) begin
            volt_reset_en <= 1'b1;
            volt_low_trip <= 1'b1;
         end else if (state_reg == ST_RUN) begin
            volt_reset_en <= det_en;
         end
         // Reset vector fetched on release, high byte then low.
         fetch_reset_vector <= state_reg == ST_LVHOLD &&
                               state_next == ST_RUN;
         if (state_reg == ST_LVHOLD && state_next == ST_RUN) begin
            vector_addr <= `SMPC_VEC_HI;
         end else if (fetch_reset_vector) begin
            vector_addr <= `SMPC_VEC_LO;
         end
         adc_run <= !in_deep && (!in_light ||
                    (ctrl1_q[`SMPC_C1_ADACK] && det_entry));
         comparator_run <= !in_deep && (!in_light ||
                           !ctrl1_q[`SMPC_C1_BGREF] || det_entry);
         irc_run <= !in_deep && (!in_light ||
                    (clksrc_q[`SMPC_CS_IREF_EN] &&
                     clksrc_q[`SMPC_CS_IREF_STOP]));
         ext_osc_run <= !in_deep && (!in_light ||
                        (clksrc_q[`SMPC_CS_EREF_EN] &&
                         clksrc_q[`SMPC_CS_EREF_STOP] &&
                         (!clksrc_q[`SMPC_CS_RANGE] ||
                          det_entry)));
         regulator_full <= !in_deep && (!in_light || dbg_entry ||
                           det_entry);
         light_stop_active <= in_light;
         deep_powerdown_active <= in_deep;
      end
   end
endmodule

// >>> verification/smpc_top_sva.sv
`timescale 1ns/1ps
module smpc_chk (
   input wire clk,
   input wire reset_n,
   input wire wake_reset_n,
   input wire supply_below_low,
   input wire [7:0] pin_ctrl_out,
   input wire core_power_on,
   input wire ram_power_on,
   input wire periph_clk_en,
   input wire system_reset_n,
   input wire illegal_op_reset,
   input wire fetch_reset_vector,
   input wire [15:0] vector_addr,
   input wire light_stop_active,
   input wire deep_powerdown_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_DEEP_POWER: assert property (deep_powerdown_active |->
      ram_power_on && !core_power_on) else $error("deep power wrong");
   AST_PINS_HELD: assert property (deep_powerdown_active &&
      $past(deep_powerdown_active) |-> $stable(pin_ctrl_out))
      else $error("pins moved in deep powerdown");
   AST_WAKE_PIN: assert property (deep_powerdown_active &&
      !wake_reset_n |-> ##[1:4] !deep_powerdown_active)
      else $error("wake pin ignored");
   AST_RESTART_LEN: assert property ($fell(system_reset_n) |->
      !system_reset_n [*8]) else $error("restart too short");
   AST_SUPPLY_HOLD: assert property ($rose(system_reset_n) |->
      !$past(supply_below_low)) else $error("left reset while supply low");
   AST_PCLK_STOP: assert property ((light_stop_active ||
      deep_powerdown_active) |-> !periph_clk_en)
      else $error("peripheral clock runs in stop");
   AST_ILLEGAL: assert property (illegal_op_reset |->
      !light_stop_active && !deep_powerdown_active && !system_reset_n
      ##1 !illegal_op_reset) else $error("stop entered while disabled");
   AST_VEC_ORDER: assert property (fetch_reset_vector |->
      vector_addr == 16'hFFFE ##1 vector_addr == 16'hFFFF)
      else $error("vector fetch order wrong");
endmodule

bind smpc_top smpc_chk chk_u (.clk(clk), .reset_n(reset_n),
   .wake_reset_n(wake_reset_n), .supply_below_low(supply_below_low),
   .pin_ctrl_out(pin_ctrl_out), .core_power_on(core_power_on),
   .ram_power_on(ram_power_on), .periph_clk_en(periph_clk_en),
   .system_reset_n(system_reset_n), .illegal_op_reset(illegal_op_reset),
   .fetch_reset_vector(fetch_reset_vector), .vector_addr(vector_addr),
   .light_stop_active(light_stop_active),
   .deep_powerdown_active(deep_powerdown_active));

// >>> verification/smpc_wake_partner.sv
`timescale 1ns/1ps
module smpc_wake_partner (
   input wire clk,
   input wire reset_n,
   input wire fire_pin,
   input wire fire_rtc,
   output wire wake_reset_n,
   output logic rtc_event
);
   logic [2:0] cnt_reg;
   // The pin is held low for five cycles, like a slow external supervisor,
   // so the device cannot rely on a one-cycle pulse.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 3'h0;
         rtc_event <= 1'b0;
      end else begin
         if (fire_pin)
            cnt_reg <= 3'h5;
         else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
         rtc_event <= fire_rtc;
      end
   end
   assign wake_reset_n = (cnt_reg == 3'h0);
endmodule

// >>> verification/smpc_top_bench.sv
`timescale 1ns/1ps
`include "smpc_map.vh"
module smpc_top_bench;
   logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, smp;
   logic stop_request, supply_low, irq_wake, fire_pin, fire_rtc;
   logic [7:0] awaddr, araddr, pin_ctrl_live, c1, cs, p0;
   logic [31:0] wdata;
   wire awready, wready, bvalid, arready, rvalid, wake_n, rtc_event;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] pins;
   wire [15:0] vaddr;
   wire core, ram, pclk, dclk, sysrst_n, illegal, lvdre, trip, fetch;
   wire adc, cmpr, irc, eosc, regf, light, deep;
   wire [19:0] obs = {cmpr, pins, lvdre, trip, core, pclk, dclk, adc, irc,
      eosc, regf, light, deep};
   logic [33:0] qe[$];
   logic [33:0] qm[$];
   string qn[$];
   int err_total, tests_run, i, n;
   logic sel, dp, lv;

   smpc_top dut_u (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .stop_request(stop_request),
      .wake_reset_n(wake_n), .rtc_event(rtc_event),
      .supply_below_low(supply_low), .irq_wake(irq_wake),
      .pin_ctrl_live(pin_ctrl_live), .pin_ctrl_out(pins),
      .core_power_on(core), .ram_power_on(ram), .periph_clk_en(pclk),
      .debug_clk_en(dclk), .system_reset_n(sysrst_n),
      .illegal_op_reset(illegal), .volt_reset_en(lvdre),
      .volt_low_trip(trip), .fetch_reset_vector(fetch),
      .vector_addr(vaddr), .adc_run(adc), .comparator_run(cmpr),
      .irc_run(irc), .ext_osc_run(eosc), .regulator_full(regf),
      .light_stop_active(light),
      .deep_powerdown_active(deep));
   smpc_wake_partner partner_u (.clk(clk), .reset_n(reset_n),
      .fire_pin(fire_pin), .fire_rtc(fire_rtc), .wake_reset_n(wake_n),
      .rtc_event(rtc_event));

   ////////////////////////////////////////////////////////////////////
   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task summarize;
      if (err_total == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task hang;
      err_total++;
      summarize();
   endtask

   task note(input string s, input logic [33:0] e, input logic [33:0] m);
      qn.push_back(s);
      qe.push_back(e);
      qm.push_back(m);
   endtask

   // Results are checked in order of appearance against the oldest note.
   task chk(input logic [33:0] seen);
      logic [33:0] e, m;
      string s;
      tests_run++;
      if (qe.size() == 0) begin
         err_total++;
         $display("wrong value unexpected expected none seen %h", seen);
      end else begin
         s = qn.pop_front();
         e = qe.pop_front();
         m = qm.pop_front();
         if ((seen & m) !== (e & m)) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", s, e, seen);
         end
      end
   endtask

   always @(posedge clk) begin
      if (bvalid && bready)
         chk({bresp, 32'h0});
      if (rvalid && rready)
         chk({rresp, rdata});
      if (smp)
         chk({14'h0, obs});
   end

   ////////////////////////////////////////////////////////////////////
   // Bus cycles hold each channel until its own ready was sampled high.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      note("bresp", {r, 32'h0}, {2'h3, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 40);
      bready <= 1'b0;
      if (!bvalid) hang();
      @(posedge clk);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
      note("rdata", {r, 24'h0, e}, {34{1'b1}});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 40);
      rready <= 1'b0;
      if (!rvalid) hang();
      @(posedge clk);
   endtask

   // Samples the power and pin outputs one edge after the request.
   task peek(input logic [19:0] e, input logic [19:0] m);
      note("power_pins", {14'h0, e}, {14'h0, m});
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
      @(posedge clk);
   endtask

   task pulse_stop;
      stop_request <= 1'b1;
      @(posedge clk);
      stop_request <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task wait_fetch;
      n = 0;
      while (!fetch && n < 80) begin
         @(posedge clk);
         n++;
      end
      if (!fetch) hang();
      repeat (2) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      {reset_n, awvalid, wvalid, bready, arvalid, rready, smp} = 7'h0;
      {stop_request, supply_low, irq_wake, fire_pin, fire_rtc} = 5'h0;
      {awaddr, araddr, pin_ctrl_live, wdata} = 56'h0;
      err_total = 0;
      tests_run = 0;
      n = $urandom(32'h336996d1);
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(`SMPC_OFS_CTRL1, 8'h03, 2'h0);
      rd(`SMPC_OFS_CTRL2, 8'h00, 2'h0);
      rd(`SMPC_OFS_CLKSRC, 8'h01, 2'h0);
      rd(8'h10, 8'h00, 2'h2);
      wr(8'h14, 32'h1, 2'h2);
      for (i = 0; i < 6; i++) begin
         c1 = $urandom;
         c1[0] = 1'b1;
         c1[7] = 1'b0;
         c1[4] = (i == 3);
         if (i[0]) c1[3:2] = 2'b00;
         cs = $urandom;
         cs[7:5] = 3'h0;
         sel = (i > 0);
         lv = c1[1] && c1[2];
         dp = sel && !c1[3] && !lv;
         p0 = $urandom;
         wr(`SMPC_OFS_CTRL1, {24'h0, c1}, 2'h0);
         wr(`SMPC_OFS_CLKSRC, {24'h0, cs}, 2'h0);
         wr(`SMPC_OFS_CTRL2, {31'h0, sel}, 2'h0);
         pin_ctrl_live <= p0;
         pulse_stop();
         pin_ctrl_live <= ~p0;
         if (!dp) begin
            peek({!c1[6] || lv, 10'h0, 2'b10, c1[3], c1[5] && lv,
               cs[0] && cs[1], cs[2] && cs[3] && (!cs[4] || lv),
               c1[3] || lv,
               2'b10}, 20'h801FF);
            irq_wake <= 1'b1;
            @(posedge clk);
            irq_wake <= 1'b0;
            repeat (3) @(posedge clk);
            peek(20'h0, 20'h3);
         end else begin
            peek({1'b0, p0, 11'h1}, 20'hFF9FF);
            if (!c1[4]) begin
               fire_rtc <= 1'b1;
               @(posedge clk);
               fire_rtc <= 1'b0;
               repeat (3) @(posedge clk);
               peek({1'b0, p0, 11'h1}, 20'hFF9FF);
               fire_pin <= 1'b1;
            end else
               fire_rtc <= 1'b1;
            @(posedge clk);
            {fire_pin, fire_rtc} <= 2'b00;
            supply_low <= 1'b1;
            repeat (14) @(posedge clk);
            supply_low <= 1'b0;
            wait_fetch();
            peek(20'h80780, 20'h80783);
            rd(`SMPC_OFS_CTRL1, 8'h03, 2'h0);
            rd(`SMPC_OFS_CLKSRC, 8'h01, 2'h0);
            rd(`SMPC_OFS_CTRL2, 8'h04, 2'h0);
            peek({1'b0, p0, 11'h0}, 20'h7F800);
            wr(`SMPC_OFS_CTRL2, 32'h0, 2'h0);
            rd(`SMPC_OFS_CTRL2, 8'h04, 2'h0);
            wr(`SMPC_OFS_CTRL2, 32'h2, 2'h0);
            rd(`SMPC_OFS_CTRL2, 8'h00, 2'h0);
            peek({1'b0, ~p0, 11'h0}, 20'h7F800);
         end
      end
      wr(`SMPC_OFS_CTRL1, 32'h2, 2'h0);
      pulse_stop();
      wait_fetch();
      rd(`SMPC_OFS_CTRL1, 8'h03, 2'h0);
      summarize();
   end
endmodule
